// File: verilog/dcrs_regs.svh
// Register offsets, field positions and constants of the result-status block.
`ifndef DCRS_REGS_SVH
`define DCRS_REGS_SVH
// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define DCRS_OUTCOME_OFS 12'h000
`define DCRS_XFER_OFS 12'h004
`define DCRS_DFIELD_OFS 12'h008
`define DCRS_CTRL_OFS 12'h00C
`define DCRS_DRIVE_OFS 12'h010
// ------------------------------------------------------------------
// Field positions and constants
// ------------------------------------------------------------------
`define DCRS_OUT_NORMAL 2'b00
`define DCRS_OUT_ABNORMAL 2'b01
`define DCRS_OUT_INVALID 2'b10
`define DCRS_OUT_READYCHG 2'b11
`define DCRS_INVALID_STATUS 8'h80
`define DCRS_BAD_CYL 8'hFF
`define DCRS_RECAL_STEPS 7'd77
`define DCRS_CTRL_START 0
`define DCRS_CTRL_END 1
`define DCRS_CTRL_INVALID 2
`define DCRS_CTRL_ABORT 3
`define DCRS_CTRL_SEEKDONE 4
`define DCRS_CTRL_DATAREQ 5
`define DCRS_CTRL_SERVICED 6
`endif

// File: verilog/dcrs_pkg.sv
// Types shared by the result-status block.
`default_nettype none
package dcrs_pkg;
    // Command classes as decoded by the sequencer.
    typedef enum logic [3:0] {
        CMD_READ = 4'h0,
        CMD_WRITE = 4'h1,
        CMD_WRITE_DEL = 4'h2,
        CMD_FORMAT = 4'h3,
        CMD_SCAN = 4'h4,
        CMD_READ_ID = 4'h5,
        CMD_READ_CYL = 4'h6,
        CMD_SEEK = 4'h7,
        CMD_RECAL = 4'h8,
        CMD_OTHER = 4'h9
    } dcrs_cmd_t;

    // Events reported by the disk data path, one-cycle pulses.
    typedef struct packed {
        logic pastLastSector;
        logic idCrcFail;
        logic dataCrcFail;
        logic sectorMissing;
        logic idMarkMissing;
        logic dataMarkMissing;
        logic deletedMark;
        logic scanEqual;
        logic scanUnsatisfied;
        logic stepPulse;
        logic cylValid;
        logic [7:0] cylRead;
        logic [7:0] cylExpected;
    } dcrs_evt_t;

    // Block phase.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_RESULT = 3'b100
    } dcrs_state_t;
endpackage : dcrs_pkg
`default_nettype wire

// File: verilog/dcrs_status.sv
// Result-status byte builder with an AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
`include "dcrs_regs.svh"

// Functional notes
// - Outcome code in bits 7:6: normal, abnormal, invalid, ready change.
// - Seek-finished bit 5 set when a seek command completes.
// - Equipment fault on drive fault or no track zero after 77 steps.
// - Not-ready on read/write to unready drive or side 1 single-sided.
// - Bit 2 of first byte holds head side selected at interrupt.
// - Bits 1:0 of first byte hold unit number at interrupt.
// - End-of-cylinder bit 7 set on access past last sector.
// - Unused bits 6 and 3 of byte two, bit 7 of byte three read zero.
// - Data-error bit 5 set on identifier or data field CRC failure.
// - Overrun bit 4 set when host misses a byte service window.
// - No-data set when sector, clean identifier or start sector missing.
// - Not-writable set when write, deleted-write or format sees protect.
// - Missing identifier mark sets byte-two bit 0 and missing-data-mark.
// - Control-mark bit 6 set when read or scan meets deleted mark.
// - Data-field CRC bit 5 of byte three on data CRC failure.
// - Wrong-cylinder set with no-data when medium cylinder mismatches.
// - Bad-cylinder set when mismatching medium cylinder equals FF.
// - Scan-equal bit 3 set when scan equality is met.
// - Scan-unsatisfied bit 2 set when scan finds no matching sector.
// - Missing-data-mark bit 0 set when no data or deleted mark found.
// - Unknown command returns single first byte of 80 hex.
module dcrs_status
    import dcrs_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Command context from the sequencer.
    input wire dcrs_cmd_t cmdClass,
    input wire logic cmdHead,
    input wire logic [1:0] cmdUnit,
    // Data path events.
    input wire dcrs_evt_t evt,
    // Drive pins.
    input wire logic driveFault,
    input wire logic driveReady,
    input wire logic driveWriteProt,
    input wire logic driveTrack0,
    input wire logic driveTwoSide,
    // Status output.
    output logic resultValid
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstMeta_q;
    logic rstSync_q;
    logic rst_n;

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rst_n = rstSync_q;

    // ------------------------------------------------------------------
    // Drive pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] pinA_q;
    logic [4:0] pinB_q;
    logic [4:0] pinC_q;
    logic [4:0] pinS_q;
    logic faultS, readyS, wprotS, trk0S, twoSideS;

    // Three stages; a level is accepted once stages two and three agree.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinA_q <= 5'h0_0;
            pinB_q <= 5'h0_0;
            pinC_q <= 5'h0_0;
            pinS_q <= 5'h0_0;
        end else begin
            pinA_q <= {driveFault, driveReady, driveWriteProt,
                       driveTrack0, driveTwoSide};
            pinB_q <= pinA_q;
            pinC_q <= pinB_q;
            for (int i = 0; i < 5; i++) begin
                if (pinB_q[i] == pinC_q[i]) begin
                    pinS_q[i] <= pinC_q[i];
                end
            end
        end
    end
    assign {faultS, readyS, wprotS, trk0S, twoSideS} = pinS_q;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic wrPend_q;
    logic rdPend_q;
    logic [11:0] addr_q;
    logic [6:0] ctrlPulse;
    logic addrPhase;

    assign addrPhase = hsel && htrans[1] && hready;

    // Address phase capture; zero wait states, always OKAY.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wrPend_q <= addrPhase && hwrite;
            rdPend_q <= addrPhase && !hwrite;
            if (addrPhase) begin
                addr_q <= haddr;
            end
        end
    end

    // Write to the control register gives one-cycle command pulses.
    assign ctrlPulse = (wrPend_q && addr_q == `DCRS_CTRL_OFS)
                       ? hwdata[6:0] : 7'h0_0;

    // ------------------------------------------------------------------
    // Phase machine
    // ------------------------------------------------------------------
    dcrs_state_t state_q;
    dcrs_cmd_t cmd_q;
    logic startCmd;
    logic endCmd;
    logic invalidCmd;
    logic abortCmd;
    logic readyLost;

    assign startCmd = ctrlPulse[`DCRS_CTRL_START];
    assign endCmd = ctrlPulse[`DCRS_CTRL_END];
    assign invalidCmd = ctrlPulse[`DCRS_CTRL_INVALID];
    assign abortCmd = ctrlPulse[`DCRS_CTRL_ABORT];

    // Tracks idle, execution and result; a new start or invalid command always wins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cmd_q <= CMD_OTHER;
        end else if (startCmd || invalidCmd) begin
            state_q <= invalidCmd ? ST_RESULT : ST_EXEC;
            cmd_q <= cmdClass;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_RESULT: state_q <= state_q;
                ST_EXEC: begin
                    if (endCmd || abortCmd || readyLost) begin
                        state_q <= ST_RESULT;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Condition detection during execution
    // ------------------------------------------------------------------
    logic exec;
    logic readyPrev_q;
    logic [6:0] stepCnt_q;
    logic hostLate_q;

    assign exec = (state_q == ST_EXEC);
    assign readyLost = exec && (readyS != readyPrev_q);

    // Remembers ready and counts recalibration steps.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            readyPrev_q <= 1'b0;
            stepCnt_q <= 7'h00;
        end else begin
            readyPrev_q <= readyS;
            if (startCmd) begin
                stepCnt_q <= 7'h00;
            end else if (exec && evt.stepPulse
                         && stepCnt_q != `DCRS_RECAL_STEPS) begin
                stepCnt_q <= stepCnt_q + 7'h01;
            end
        end
    end

    // Byte service window: a request left pending until the next request.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hostLate_q <= 1'b0;
        end else if (startCmd || ctrlPulse[`DCRS_CTRL_SERVICED]) begin
            hostLate_q <= 1'b0;
        end else if (ctrlPulse[`DCRS_CTRL_DATAREQ]) begin
            hostLate_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------------
    logic [1:0] outcome_q;
    logic seekDone_q;
    logic eqFault_q;
    logic notReady_q;
    logic headSide_q;
    logic [1:0] unit_q;
    logic [7:0] xfer_q;
    logic [7:0] dfield_q;
    logic cylBad;
    logic cylDiff;

    assign cylDiff = evt.cylValid && (evt.cylRead != evt.cylExpected);
    assign cylBad = cylDiff && (evt.cylRead == `DCRS_BAD_CYL);

    // Outcome, seek and drive identity in the first byte.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outcome_q <= `DCRS_OUT_NORMAL;
            seekDone_q <= 1'b0;
            eqFault_q <= 1'b0;
            notReady_q <= 1'b0;
            headSide_q <= 1'b0;
            unit_q <= 2'b00;
        end else if (invalidCmd) begin
            outcome_q <= `DCRS_OUT_INVALID;
            seekDone_q <= 1'b0;
            eqFault_q <= 1'b0;
            notReady_q <= 1'b0;
            headSide_q <= 1'b0;
            unit_q <= 2'b00;
        end else if (startCmd) begin
            outcome_q <= `DCRS_OUT_NORMAL;
            seekDone_q <= 1'b0;
            eqFault_q <= faultS;
            notReady_q <= (cmdClass inside {CMD_READ, CMD_WRITE,
                           CMD_WRITE_DEL, CMD_SCAN, CMD_READ_ID,
                           CMD_READ_CYL, CMD_FORMAT})
                          && (!readyS || (cmdHead && !twoSideS));
            headSide_q <= cmdHead;
            unit_q <= cmdUnit;
        end else if (exec) begin
            if (faultS || (cmd_q == CMD_RECAL && !trk0S
                           && stepCnt_q == `DCRS_RECAL_STEPS)) begin
                eqFault_q <= 1'b1;
            end
            if (readyLost || abortCmd) begin
                outcome_q <= `DCRS_OUT_READYCHG;
            end else if (endCmd) begin
                // Any error or not-ready flag makes the end abnormal.
                if (notReady_q || eqFault_q || xfer_q != 8'h00
                    || dfield_q != 8'h00) begin
                    outcome_q <= `DCRS_OUT_ABNORMAL;
                end
                if (cmd_q == CMD_SEEK || cmd_q == CMD_RECAL) begin
                    seekDone_q <= 1'b1;
                end
                headSide_q <= cmdHead;
                unit_q <= cmdUnit;
            end
        end
    end

    // Transfer error byte; set bits clear only at a start or invalid command.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xfer_q <= 8'h00;
        end else if (startCmd || invalidCmd) begin
            xfer_q <= 8'h00;
        end else if (exec) begin
            if (evt.pastLastSector) xfer_q[7] <= 1'b1;
            if (evt.idCrcFail || evt.dataCrcFail) xfer_q[5] <= 1'b1;
            if (hostLate_q && ctrlPulse[`DCRS_CTRL_DATAREQ]) begin
                xfer_q[4] <= 1'b1;
            end
            if ((evt.sectorMissing && cmd_q inside {CMD_READ,
                 CMD_WRITE_DEL, CMD_SCAN, CMD_READ_CYL})
                || (cmd_q == CMD_READ_ID && (evt.idCrcFail
                    || evt.idMarkMissing)) || cylDiff) begin
                xfer_q[2] <= 1'b1;
            end
            if (wprotS && cmd_q inside {CMD_WRITE, CMD_WRITE_DEL,
                                        CMD_FORMAT}) begin
                xfer_q[1] <= 1'b1;
            end
            if (evt.idMarkMissing) xfer_q[0] <= 1'b1;
        end
    end

    // Data field byte.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dfield_q <= 8'h00;
        end else if (startCmd || invalidCmd) begin
            dfield_q <= 8'h00;
        end else if (exec) begin
            if (evt.deletedMark && cmd_q inside {CMD_READ, CMD_SCAN}) begin
                dfield_q[6] <= 1'b1;
            end
            if (evt.dataCrcFail) dfield_q[5] <= 1'b1;
            if (cylDiff) dfield_q[4] <= 1'b1;
            if (evt.scanEqual) dfield_q[3] <= 1'b1;
            if (evt.scanUnsatisfied) dfield_q[2] <= 1'b1;
            if (cylBad) dfield_q[1] <= 1'b1;
            if (evt.dataMarkMissing || evt.idMarkMissing) begin
                dfield_q[0] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------------
    logic [7:0] outcomeByte;
    logic [7:0] xferByte;
    logic [7:0] dfieldByte;

    assign outcomeByte = {outcome_q, seekDone_q, eqFault_q, notReady_q,
                          headSide_q, unit_q};
    assign xferByte = {xfer_q[7], 1'b0, xfer_q[5:4], 1'b0,
                       xfer_q[2:0]};
    assign dfieldByte = {1'b0, dfield_q[6:0]};

    // Read data is registered in the address phase for the data phase.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            resultValid <= 1'b0;
        end else begin
            resultValid <= (state_q == ST_RESULT);
            if (addrPhase && !hwrite) begin
                unique case (haddr)
                    `DCRS_OUTCOME_OFS: hrdata <= {24'h00_0000, outcomeByte};
                    `DCRS_XFER_OFS: hrdata <= {24'h00_0000, xferByte};
                    `DCRS_DFIELD_OFS: hrdata <= {24'h00_0000, dfieldByte};
                    `DCRS_DRIVE_OFS: hrdata <= {24'h00_0000, faultS, wprotS,
                        readyS, trk0S, twoSideS, headSide_q, unit_q};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_invalid_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        invalidCmd |=> outcomeByte == `DCRS_INVALID_STATUS)
        else $error("invalid command status not 80");
    a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !xferByte[6] && !xferByte[3] && !dfieldByte[7])
        else $error("unused status bit set");
    a_start_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        startCmd |=> xfer_q == 8'h00 && dfield_q == 8'h00)
        else $error("error flags not cleared at start");
    a_id_mark_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && !startCmd && !invalidCmd && evt.idMarkMissing
        |=> xfer_q[0] && dfield_q[0])
        else $error("missing mark flags not paired");
    a_bad_cyl: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && !startCmd && !invalidCmd && cylBad
        |=> dfield_q[1] && dfield_q[4] && xfer_q[2])
        else $error("bad cylinder not flagged");
    a_ready_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
        readyLost && !startCmd && !invalidCmd
        |=> outcome_q == `DCRS_OUT_READYCHG && state_q == ST_RESULT)
        else $error("ready change not reported");
    a_seek_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && endCmd && cmd_q == CMD_SEEK && !startCmd && !invalidCmd
        |=> seekDone_q)
        else $error("seek finished flag missing");
    a_data_crc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exec && !startCmd && !invalidCmd && evt.dataCrcFail
        |=> dfield_q[5] && xfer_q[5])
        else $error("data crc flags missing");

endmodule : dcrs_status
`default_nettype wire

// File: test/dcrs_drive_model.sv
// Behavioural model of the disk drive seen by the result-status block.
`timescale 1ns/1ns
`default_nettype none
module dcrs_drive_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Step request, and the step at which track zero shows (0 = never).
    input wire logic stepGo,
    input wire logic [6:0] zeroAt,
    // Drive outputs.
    output logic stepPulse,
    output logic driveTrack0
);
    logic [6:0] left_q;
    logic [6:0] done_q;

    // Gives up to 77 steps, one every second cycle, and stops at track zero.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            left_q <= '0;
            done_q <= '0;
            stepPulse <= 1'b0;
            driveTrack0 <= 1'b0;
        end else if (stepGo) begin
            left_q <= 7'h4D;
            done_q <= '0;
            driveTrack0 <= 1'b0;
        end else if (left_q != 0 && !driveTrack0 && !stepPulse) begin
            stepPulse <= 1'b1;
            left_q <= left_q - 7'h1;
            done_q <= done_q + 7'h1;
            driveTrack0 <= (done_q + 7'h1 == zeroAt);
        end else begin
            stepPulse <= 1'b0;
        end
    end
endmodule : dcrs_drive_model
`default_nettype wire

// File: test/test_disk_controller_result_status.sv
// Self-checking bench of the result-status block.
`timescale 1ns/1ns
`default_nettype none
`include "dcrs_regs.svh"
module test_disk_controller_result_status
    import dcrs_pkg::*;
;
    logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, resultValid;
    logic cmdHead, driveFault, driveReady, driveWriteProt, driveTwoSide;
    logic driveTrack0, stepPulse, stepGo, hd;
    logic [11:0] haddr;
    logic [1:0] htrans, cmdUnit, un;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [6:0] zeroAt;
    logic [7:0] cr;
    dcrs_cmd_t cmdClass;
    dcrs_evt_t evtTb, evtBus;
    int fail_count, cmp_count;
    integer seed;
    int evBit[9] = '{26, 25, 24, 23, 22, 21, 20, 19, 18};
    logic [7:0] e1Tab[9] = '{8'h80, 8'h20, 8'h20, 8'h04, 8'h01, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic [7:0] e2Tab[9] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h01, 8'h01,
        8'h40, 8'h08, 8'h04};

    // Step pulses come from the drive model, all other events from here.
    always_comb begin
        evtBus = evtTb;
        evtBus.stepPulse = stepPulse;
    end

    dcrs_status u_dcrs_status (.clk_sys(clk_sys), .arst_n(arst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmdClass(cmdClass), .cmdHead(cmdHead), .cmdUnit(cmdUnit),
        .evt(evtBus), .driveFault(driveFault), .driveReady(driveReady),
        .driveWriteProt(driveWriteProt), .driveTrack0(driveTrack0),
        .driveTwoSide(driveTwoSide), .resultValid(resultValid));

    dcrs_drive_model u_dcrs_drive_model (.clk_sys(clk_sys),
        .arst_n(arst_n), .stepGo(stepGo), .zeroAt(zeroAt),
        .stepPulse(stepPulse), .driveTrack0(driveTrack0));

    // Free-running system clock, 20 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got,
                exp);
        end
    endtask : check

    // Waits for hready high at a rising edge, with a bound.
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (n >= 16) check({31'h0, hreadyout}, 32'h1, "bus stall");
    endtask : waitRdy

    // One single AHB-Lite word transfer, address then data phase.
    task automatic ahb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        waitRdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitRdy;
        q = hrdata;
        check({31'h0, hresp}, 32'h0, "response");
    endtask : ahb

    task automatic ctl(input int b);
        ahb(1'b1, `DCRS_CTRL_OFS, 32'h1 << b);
    endtask : ctl

    task automatic rdChk(input logic [11:0] a, input logic [7:0] e, m);
        ahb(1'b0, a, 32'h0);
        check(q & {24'hFF_FFFF, m}, {24'h0, e & m}, "status byte");
    endtask : rdChk

    function automatic logic [7:0] st0(input logic [1:0] oc,
        input logic [2:0] fl);
        return {oc, fl, hd, un};
    endfunction : st0

    // Starts a command with a random head and unit.
    task automatic newCmd(input dcrs_cmd_t c, input logic fh);
        {hd, un} = 3'($random(seed));
        hd = hd | fh;
        cmdClass <= c;
        cmdHead <= hd;
        cmdUnit <= un;
        @(posedge clk_sys);
        ctl(`DCRS_CTRL_START);
        repeat (2) @(posedge clk_sys);
    endtask : newCmd

    task automatic pulse(input logic [26:0] v);
        evtTb <= dcrs_evt_t'(v);
        @(posedge clk_sys);
        evtTb <= '0;
        @(posedge clk_sys);
    endtask : pulse

    // Ends the command and checks the three result bytes under masks.
    task automatic result(input logic [7:0] e0, m0, e1, m1, e2, m2);
        ctl(`DCRS_CTRL_END);
        repeat (3) @(posedge clk_sys);
        check({31'h0, resultValid}, 32'h1, "result phase");
        rdChk(`DCRS_OUTCOME_OFS, e0, m0);
        rdChk(`DCRS_XFER_OFS, e1, m1);
        rdChk(`DCRS_DFIELD_OFS, e2, m2);
    endtask : result

    // Cuts a hung run short.
    initial begin
        #(20 * 8000);
        fail_count++;
        test_done;
    end

    // Main sequence.
    initial begin
        seed = 32'h094e;
        {hsel, hwrite, cmdHead, driveFault, driveWriteProt, stepGo} = '0;
        {haddr, htrans, cmdUnit, hwdata, zeroAt} = '0;
        {driveReady, driveTwoSide} = 2'b11;
        hsize = 3'b010;
        cmdClass = CMD_OTHER;
        evtTb = '0;
        arst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check({30'h0, hreadyout, resultValid}, 32'h2, "after reset");
        rdChk(12'h020, 8'h00, 8'hFF);
        newCmd(CMD_READ, 1'b0);
        result(st0(2'b00, 3'b000), 8'hFF, 0, 8'hFF,
            0, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            newCmd(i >= 6 ? CMD_SCAN : CMD_READ, 1'b0);
            pulse(27'h1 << evBit[i]);
            result(st0(2'b01, 3'b000), 8'hFF, e1Tab[i], 8'hFF,
                e2Tab[i], 8'hFF);
        end
        for (int i = 0; i < 2; i++) begin
            cr = 8'($random(seed)) & 8'hFE;
            if (i == 1) cr = 8'hFF;
            newCmd(CMD_READ, 1'b0);
            pulse({11'h001, cr, cr + 8'h01});
            result(st0(2'b01, 3'b000), 8'hFF, 8'h04, 8'hFF,
                i ? 8'h12 : 8'h10, 8'hFF);
        end
        newCmd(CMD_SEEK, 1'b0);
        result(st0(2'b00, 3'b100), 8'h3F, 0, 8'hFF, 0, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            newCmd(CMD_RECAL, 1'b0);
            zeroAt <= i ? 7'h0 : 7'h4C;
            stepGo <= 1'b1;
            @(posedge clk_sys);
            stepGo <= 1'b0;
            repeat (200) @(posedge clk_sys);
            result(st0(2'b00, {2'b11 & {1'b1, i[0]}, 1'b0}), 8'h3F,
                0, 8'hFF, 0, 8'hFF);
        end
        driveWriteProt <= 1'b1;
        repeat (8) @(posedge clk_sys);
        for (int i = 1; i < 4; i++) begin
            newCmd(dcrs_cmd_t'(i), 1'b0);
            result(st0(2'b01, 3'b000), 8'hFF, 8'h02, 8'hFF,
                0, 8'hFF);
        end
        {driveWriteProt, driveFault} <= 2'b01;
        repeat (8) @(posedge clk_sys);
        newCmd(CMD_READ, 1'b0);
        result(st0(2'b01, 3'b010), 8'hFF, 0, 8'hFF, 0, 8'hFF);
        {driveFault, driveReady} <= 2'b00;
        repeat (8) @(posedge clk_sys);
        newCmd(CMD_READ, 1'b0);
        result(st0(2'b01, 3'b001), 8'hFF, 0, 8'hFF, 0, 8'hFF);
        {driveReady, driveTwoSide} <= 2'b10;
        repeat (8) @(posedge clk_sys);
        newCmd(CMD_WRITE, 1'b1);
        result(st0(2'b01, 3'b001), 8'hFF, 0, 8'hFF, 0, 8'hFF);
        driveTwoSide <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            newCmd(CMD_READ, 1'b0);
            ctl(`DCRS_CTRL_DATAREQ);
            ctl(i ? `DCRS_CTRL_DATAREQ : `DCRS_CTRL_SERVICED);
            result(0, 8'h00, i ? 8'h10 : 8'h00, 8'hFF, 0, 8'hFF);
        end
        newCmd(CMD_READ, 1'b0);
        driveReady <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rdChk(`DCRS_OUTCOME_OFS, 8'hC0, 8'hC0);
        driveReady <= 1'b1;
        repeat (8) @(posedge clk_sys);
        newCmd(CMD_READ, 1'b0);
        ctl(`DCRS_CTRL_ABORT);
        repeat (3) @(posedge clk_sys);
        rdChk(`DCRS_OUTCOME_OFS, 8'hC0, 8'hC0);
        cmdClass <= CMD_OTHER;
        ctl(`DCRS_CTRL_INVALID);
        repeat (3) @(posedge clk_sys);
        rdChk(`DCRS_OUTCOME_OFS, 8'h80, 8'hFF);
        // Pin snapshot: ready and two-sided high, head and unit cleared.
        rdChk(`DCRS_DRIVE_OFS, 8'h28, 8'hFF);
        test_done;
    end
endmodule : test_disk_controller_result_status
`default_nettype wire
